// ===== hw/icfs_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "icfs_regs.svh"
module icfs_top
    import icfs_pkg::*;
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // register port from the command decoder
    input  wire logic [7:0]   reg_addr,
    input  wire logic         reg_wr_en,
    input  wire icfs_byte_t   reg_wr_data,
    input  wire logic         reg_rd_en,
    output icfs_byte_t        reg_rd_data,
    output logic              reg_rd_valid,
    // calibration engine results
    input  wire logic         cal_ofs_load,
    input  wire icfs_word24_t cal_ofs_value,
    input  wire logic         cal_gain_load,
    input  wire icfs_word24_t cal_gain_value,
    // filter configuration from the other config byte
    input  wire logic [1:0]   filter_path_select,
    // filtered stream
    input  wire logic         filt_valid,
    input  wire icfs_sample_t filt_data,
    // corrected stream
    output logic              out_valid,
    output icfs_sample_t      out_data,
    // converter restart after any write to a mapped register
    output logic              conv_restart,
    // analog and filter configuration
    output icfs_input_sel_t   input_select,
    output logic              amp_chopping_enable,
    output logic [2:0]        amp_gain_select,
    output logic [15:0]       highpass_corner
);
    localparam int NB = `ICFS_NUM_BYTES;
    localparam icfs_byte_t RST [NB] = '{
        `ICFS_RST_INPUT_CFG, `ICFS_RST_HPF_LOW, `ICFS_RST_HPF_HIGH,
        `ICFS_RST_OFS_BYTE, `ICFS_RST_OFS_BYTE, `ICFS_RST_OFS_BYTE,
        `ICFS_RST_GAIN_LOW, `ICFS_RST_GAIN_MID, `ICFS_RST_GAIN_HIGH};
    localparam icfs_byte_t ADDR [NB] = '{
        `ICFS_ADDR_INPUT_CFG, `ICFS_ADDR_HPF_LOW, `ICFS_ADDR_HPF_HIGH,
        `ICFS_ADDR_OFS_LOW, `ICFS_ADDR_OFS_MID, `ICFS_ADDR_OFS_HIGH,
        `ICFS_ADDR_GAIN_LOW, `ICFS_ADDR_GAIN_MID, `ICFS_ADDR_GAIN_HIGH};

    icfs_byte_t   bytes [NB];
    logic         wr_hit [NB];
    logic         ld_hit [NB];
    icfs_byte_t   ld_byte [NB];
    icfs_word24_t offset_correction_word;
    icfs_word24_t gain_correction_word;
    logic         sc_valid;
    icfs_sample_t sc_data;

    ////////////////////////////////////////////////////////////////////
    // register bytes
    always_comb begin
        for (int i = 0; i < NB; i++) begin
            wr_hit[i]  = reg_wr_en && (reg_addr == ADDR[i]);
            ld_hit[i]  = 1'b0;
            ld_byte[i] = '0;
        end
        for (int j = 0; j < 3; j++) begin
            ld_hit[3 + j]  = cal_ofs_load;
            ld_byte[3 + j] = cal_ofs_value[8*j +: 8];
            ld_hit[6 + j]  = cal_gain_load;
            ld_byte[6 + j] = cal_gain_value[8*j +: 8];
        end
    end

    // reserved top bit of the input config is held at zero whatever is written
    for (genvar g = 0; g < NB; g++) begin : g_byte
        icfs_cfg_byte #(
            .RESET_VAL (RST[g]),
            .WR_MASK   ((g == 0) ? `ICFS_MASK_INPUT_CFG : `ICFS_MASK_FULL)
        ) u_byte (
            .clk       (clk),
            .sys_rst   (sys_rst),
            .wr_en     (wr_hit[g]),
            .wr_data   (reg_wr_data),
            .load_en   (ld_hit[g]),
            .load_data (ld_byte[g]),
            .value     (bytes[g])
        );
    end

    assign offset_correction_word = {bytes[5], bytes[4], bytes[3]};
    assign gain_correction_word   = {bytes[8], bytes[7], bytes[6]};
    // gain change leaves correction words alone; host recalibrates
    assign input_select        = icfs_input_sel_t'(bytes[0][`ICFS_MUX_HI:`ICFS_MUX_LO]);
    assign amp_chopping_enable = bytes[0][`ICFS_AMP_CHOPPING_ENABLE_BIT];
    assign amp_gain_select     = bytes[0][`ICFS_GAIN_HI:`ICFS_GAIN_LO];
    assign highpass_corner     = {bytes[2], bytes[1]};

    ////////////////////////////////////////////////////////////////////
    // read port: one cycle, unmapped addresses read zero
    icfs_byte_t rd_data_ff, nxt_rd_data;
    logic       rd_valid_ff, nxt_rd_valid;

    always_comb begin
        nxt_rd_valid = reg_rd_en;
        nxt_rd_data  = rd_data_ff;
        if (reg_rd_en) begin
            nxt_rd_data = '0;
            for (int i = 0; i < NB; i++) begin
                if (reg_addr == ADDR[i]) begin
                    nxt_rd_data = bytes[i];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data_ff  <= '0;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_data_ff  <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
        end
    end

    assign reg_rd_data  = rd_data_ff;
    assign reg_rd_valid = rd_valid_ff;

    ////////////////////////////////////////////////////////////////////
    // correction datapath
    icfs_scaler u_scaler (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .ofs_word  (offset_correction_word),
        .gain_word (gain_correction_word),
        .bypass    (filter_path_select == `ICFS_FILTER_SINC),
        .in_valid  (filt_valid),
        .in_data   (filt_data),
        .out_valid (sc_valid),
        .out_data  (sc_data)
    );

    ////////////////////////////////////////////////////////////////////
    // restart and discard of readings after a write
    logic         restart_ff, nxt_restart;
    logic [5:0]   discard_ff, nxt_discard;
    logic         ov_ff, nxt_ov;
    icfs_sample_t od_ff, nxt_od;
    logic         any_wr;

    always_comb begin
        any_wr      = 1'b0;
        for (int i = 0; i < NB; i++) begin
            any_wr = any_wr | wr_hit[i];
        end
        nxt_restart = any_wr;
        nxt_discard = discard_ff;
        nxt_ov      = 1'b0;
        nxt_od      = od_ff;
        // a write restarts the count even mid-discard
        if (any_wr) begin
            nxt_discard = `ICFS_DISCARD_COUNT;
        end else if (sc_valid && discard_ff != '0) begin
            nxt_discard = discard_ff - 6'h01;
        end else if (sc_valid) begin
            nxt_ov = 1'b1;
            nxt_od = sc_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            restart_ff <= 1'b0;
            discard_ff <= '0;
            ov_ff      <= 1'b0;
            od_ff      <= '0;
        end else begin
            restart_ff <= nxt_restart;
            discard_ff <= nxt_discard;
            ov_ff      <= nxt_ov;
            od_ff      <= nxt_od;
        end
    end

    assign conv_restart = restart_ff;
    assign out_valid    = ov_ff;
    assign out_data     = od_ff;
endmodule
`default_nettype wire

// ===== common/icfs_regs.svh
// Behaviour
// - bits 6:4 choose the input pair, internal short, tied pairs or external short.
// - bit 3 enables amplifier chopping; it is set after reset.
// - bits 2:0 pick gain 1 to 64 in powers of two; 111 undefined.
// - high-pass corner is 16 bits, low byte at 03h, high at 04h.
// - offset word is 24 bits over 05h, 06h, 07h, 07h most significant.
// - gain word is 24 bits over 08h, 09h, 0Ah, 0Ah most significant.
// - subtract offset first, then multiply by gain word over 400000h.
// - correction words load from host writes or from a finished calibration.
// - sinc-only filter path skips correction and passes data unscaled.
// - offset is left-aligned to 32 bits, so 000001h gives 00000100h.
// - offset word is two's complement, 7FFFFFh to 800000h.
// - zero offset applies nothing; offset bytes reset to zero.
// - gain word is unsigned, 400000h is unity and the reset value.
// - gain scales linearly: 800000h twice, 200000h half, zero gives zero.
// - filter select code 01 is the sinc-only path that bypasses correction.
// - reads and writes per register; each write restarts, losing 63 readings.
`ifndef ICFS_REGS_SVH
`define ICFS_REGS_SVH

`define ICFS_ADDR_INPUT_CFG  8'h02
`define ICFS_ADDR_HPF_LOW    8'h03
`define ICFS_ADDR_HPF_HIGH   8'h04
`define ICFS_ADDR_OFS_LOW    8'h05
`define ICFS_ADDR_OFS_MID    8'h06
`define ICFS_ADDR_OFS_HIGH   8'h07
`define ICFS_ADDR_GAIN_LOW   8'h08
`define ICFS_ADDR_GAIN_MID   8'h09
`define ICFS_ADDR_GAIN_HIGH  8'h0a
`define ICFS_NUM_BYTES       9

`define ICFS_RST_INPUT_CFG   8'h08
`define ICFS_RST_HPF_LOW     8'h32
`define ICFS_RST_HPF_HIGH    8'h03
`define ICFS_RST_OFS_BYTE    8'h00
`define ICFS_RST_GAIN_LOW    8'h00
`define ICFS_RST_GAIN_MID    8'h00
`define ICFS_RST_GAIN_HIGH   8'h40

`define ICFS_MASK_INPUT_CFG  8'h7f
`define ICFS_MASK_FULL       8'hff

`define ICFS_MUX_HI          6
`define ICFS_MUX_LO          4
`define ICFS_AMP_CHOPPING_ENABLE_BIT        3
`define ICFS_GAIN_HI         2
`define ICFS_GAIN_LO         0

`define ICFS_FILTER_SINC     2'h1
`define ICFS_OFS_ALIGN       8
`define ICFS_GAIN_SHIFT      22
`define ICFS_DISCARD_COUNT   6'h3f

`endif

// ===== common/icfs_pkg.sv
`default_nettype none
package icfs_pkg;
    typedef logic [7:0]         icfs_byte_t;
    typedef logic [23:0]        icfs_word24_t;
    typedef logic signed [31:0] icfs_sample_t;
    typedef enum logic [2:0] {
        ICFS_IN_FIRST_PAIR  = 3'h0,
        ICFS_IN_SECOND_PAIR = 3'h1,
        ICFS_IN_INT_SHORT   = 3'h2,
        ICFS_IN_PAIRS_TIED  = 3'h3,
        ICFS_IN_EXT_SHORT   = 3'h4
    } icfs_input_sel_t;
endpackage
`default_nettype wire

// ===== hw/icfs_cfg_byte.sv
`timescale 1ns/1ps
`default_nettype none
module icfs_cfg_byte
    import icfs_pkg::*;
#(
    parameter icfs_byte_t RESET_VAL = 8'h00,
    parameter icfs_byte_t WR_MASK   = 8'hff
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // host write
    input  wire logic       wr_en,
    input  wire icfs_byte_t wr_data,
    // calibration load
    input  wire logic       load_en,
    input  wire icfs_byte_t load_data,
    // stored byte
    output icfs_byte_t      value
);
    icfs_byte_t value_ff;
    icfs_byte_t nxt_value;

    // calibration result wins over a same-cycle host write
    always_comb begin
        nxt_value = value_ff;
        if (load_en) begin
            nxt_value = load_data & WR_MASK;
        end else if (wr_en) begin
            nxt_value = wr_data & WR_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            value_ff <= RESET_VAL;
        end else begin
            value_ff <= nxt_value;
        end
    end

    assign value = value_ff;
endmodule
`default_nettype wire

// ===== hw/icfs_scaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "icfs_regs.svh"
module icfs_scaler
    import icfs_pkg::*;
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // correction words and mode
    input  wire icfs_word24_t ofs_word,
    input  wire icfs_word24_t gain_word,
    input  wire logic         bypass,
    // filtered stream in
    input  wire logic         in_valid,
    input  wire icfs_sample_t in_data,
    // corrected stream out, two cycles later
    output logic              out_valid,
    output icfs_sample_t      out_data
);
    logic signed [32:0] diff_ff, nxt_diff;
    icfs_sample_t       raw_ff, nxt_raw;
    logic               byp_ff, nxt_byp;
    logic               v1_ff, nxt_v1;
    logic               v2_ff, nxt_v2;
    icfs_sample_t       res_ff, nxt_res;
    logic signed [57:0] prod;
    logic signed [35:0] scaled;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_v1   = in_valid;
        nxt_raw  = in_data;
        nxt_byp  = bypass;
        // offset signed, sits in the top 24 of 32 bits
        nxt_diff = {in_data[31], in_data}
                 - {ofs_word[23], ofs_word, {`ICFS_OFS_ALIGN{1'b0}}};
        prod     = diff_ff * $signed({1'b0, gain_word});
        scaled   = prod[57:`ICFS_GAIN_SHIFT];
        nxt_v2   = v1_ff;
        if (byp_ff) begin
            nxt_res = raw_ff;
        end else if (scaled[35:31] != {5{scaled[31]}}) begin
            // wrap would flip the sign of a near-full-scale reading
            nxt_res = scaled[35] ? 32'sh80000000 : 32'sh7fffffff;
        end else begin
            nxt_res = scaled[31:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            diff_ff <= '0;
            raw_ff  <= '0;
            byp_ff  <= 1'b0;
            v1_ff   <= 1'b0;
            v2_ff   <= 1'b0;
            res_ff  <= '0;
        end else begin
            diff_ff <= nxt_diff;
            raw_ff  <= nxt_raw;
            byp_ff  <= nxt_byp;
            v1_ff   <= nxt_v1;
            v2_ff   <= nxt_v2;
            res_ff  <= nxt_res;
        end
    end

    assign out_valid = v2_ff;
    assign out_data  = res_ff;
endmodule
`default_nettype wire

// ===== test/icfs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module icfs_checker
    import icfs_pkg::*;
(
    // clock and reset
    input wire logic            clk,
    input wire logic            sys_rst,
    // register port
    input wire logic [7:0]      reg_addr,
    input wire logic            reg_wr_en,
    input wire icfs_byte_t      reg_wr_data,
    input wire logic            reg_rd_en,
    input wire icfs_byte_t      reg_rd_data,
    input wire logic            reg_rd_valid,
    // stream
    input wire logic [1:0]      filter_path_select,
    input wire logic            filt_valid,
    input wire icfs_sample_t    filt_data,
    input wire logic            out_valid,
    input wire icfs_sample_t    out_data,
    input wire logic            conv_restart,
    // config levels
    input wire icfs_input_sel_t input_select,
    input wire logic            amp_chopping_enable,
    input wire logic [2:0]      amp_gain_select,
    input wire logic [15:0]     highpass_corner
);
    wire logic mapped = (reg_addr >= 8'h02) && (reg_addr <= 8'h0a);
    wire logic wr_map = reg_wr_en && mapped;
    wire logic wr_cfg = reg_wr_en && (reg_addr == 8'h02);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_bypass_in;
        filt_valid && (filter_path_select == 2'h1);
    endsequence
    sequence s_pass_out;
        ##3 (!out_valid || (out_data == $past(filt_data, 3)));
    endsequence
    AST_RD_VALID: assert property (reg_rd_valid == $past(reg_rd_en))
        else $error("read valid not one cycle after strobe");
    AST_RD_UNMAP: assert property (reg_rd_en && !mapped |=> reg_rd_data == 8'h00)
        else $error("unmapped read not zero");
    AST_RESTART: assert property (conv_restart == $past(wr_map))
        else $error("restart not tied to a mapped write");
    AST_DISCARD: assert property (wr_map |=> !out_valid [*8])
        else $error("result emitted right after a write");
    AST_CFG_WR: assert property (wr_cfg |=>
        {input_select, amp_chopping_enable, amp_gain_select} == $past(reg_wr_data[6:0]))
        else $error("config byte fields wrong after write");
    AST_CFG_HOLD: assert property (!wr_cfg |=>
        $stable({input_select, amp_chopping_enable, amp_gain_select}))
        else $error("config fields moved without a write");
    AST_HPF_LOW: assert property (reg_wr_en && reg_addr == 8'h03 |=>
        highpass_corner[7:0] == $past(reg_wr_data))
        else $error("corner low byte wrong");
    AST_HPF_HIGH: assert property (reg_wr_en && reg_addr == 8'h04 |=>
        highpass_corner[15:8] == $past(reg_wr_data))
        else $error("corner high byte wrong");
    AST_OUT_LAT: assert property (out_valid |-> $past(filt_valid, 3))
        else $error("result without input three cycles before");
    AST_BYPASS: assert property (s_bypass_in |-> s_pass_out)
        else $error("sinc path result was scaled");
endmodule
`default_nettype wire

// ===== test/icfs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module icfs_host_model
    import icfs_pkg::*;
(
    // clock
    input wire logic       clk,
    // register port
    output logic [7:0]     reg_addr,
    output logic           reg_wr_en,
    output icfs_byte_t     reg_wr_data,
    output logic           reg_rd_en,
    input wire icfs_byte_t reg_rd_data,
    input wire logic       reg_rd_valid
);
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en = 1'b0;
    end
    // released lines show the inverse so a stale value is never trusted
    task automatic wr(input logic [7:0] a, input icfs_byte_t d);
        @(negedge clk);
        reg_addr = a;
        reg_wr_data = (a == 8'h02) ? (d & 8'h7f) : d;
        reg_wr_en = 1'b1;
        @(negedge clk);
        reg_wr_en = 1'b0;
        reg_addr = ~reg_addr;
        reg_wr_data = ~reg_wr_data;
    endtask
    task automatic rd(input logic [7:0] a, output icfs_byte_t d, output logic v);
        @(negedge clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clk);
        reg_rd_en = 1'b0;
        reg_addr = ~reg_addr;
        d = reg_rd_data;
        v = reg_rd_valid;
    endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import icfs_pkg::*;
    logic            clk = 1'b0;
    logic            sys_rst = 1'b1;
    wire logic [7:0] reg_addr;
    wire logic       reg_wr_en;
    wire icfs_byte_t reg_wr_data;
    wire logic       reg_rd_en;
    icfs_byte_t      reg_rd_data;
    logic            reg_rd_valid;
    logic            cal_ofs_load, cal_gain_load, filt_valid, out_valid, conv_restart;
    icfs_word24_t    cal_ofs_value, cal_gain_value;
    logic [1:0]      filter_path_select;
    icfs_sample_t    filt_data, out_data;
    icfs_input_sel_t input_select;
    logic            amp_chopping_enable;
    logic [2:0]      amp_gain_select;
    logic [15:0]     highpass_corner;
    int              mismatches = 0;
    int              n_tests = 0;
    int              cyc = 0;
    int              nout = 0;
    icfs_byte_t      rst_tab [9] = '{8'h08, 8'h32, 8'h03, 8'h00, 8'h00, 8'h00,
                                     8'h00, 8'h00, 8'h40};
    icfs_word24_t    t_ofs [7] = '{24'h000001, 24'h800000, 24'h7fffff, 24'h000000,
                                   24'h000000, 24'h000000, 24'h123456};
    icfs_word24_t    t_gain [7] = '{24'h400000, 24'h400000, 24'h800000, 24'h800000,
                                    24'h200000, 24'h000000, 24'h800000};
    logic [1:0]      t_flt [7] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h0, 2'h2, 2'h1};
    icfs_sample_t    t_in [7] = '{32'h00000000, 32'h00000000, 32'h00000000, 32'h00001000,
                                  32'h00001000, 32'h00001000, 32'h01234567};
    always #5 clk = ~clk;
    icfs_top icfs_top_inst (.*);
    icfs_host_model icfs_host_model_inst (.*);
    always @(posedge clk) begin
        nout <= nout + int'(out_valid);
        cyc <= cyc + 1;
        // ceiling well above the ~660 cycles the sequence needs
        if (cyc == 6000) begin
            mismatches++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic rdchk(input logic [7:0] a, input icfs_byte_t e);
        icfs_byte_t d;
        logic       v;
        icfs_host_model_inst.rd(a, d, v);
        chk("rd_valid", v, 1);
        chk("rd_data", d, e);
    endtask
    task automatic wr24(input logic [7:0] a, input icfs_word24_t w);
        icfs_host_model_inst.wr(a, w[7:0]);
        icfs_host_model_inst.wr(a + 8'h01, w[15:8]);
        icfs_host_model_inst.wr(a + 8'h02, w[23:16]);
    endtask
    task automatic do_reset;
        sys_rst = 1'b1;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
    endtask
    function automatic icfs_sample_t ref_out(icfs_word24_t o, icfs_word24_t g,
                                             logic [1:0] f, icfs_sample_t x);
        logic signed [63:0] d;
        logic signed [63:0] p;
        d = $signed({{32{x[31]}}, x}) - $signed({{32{o[23]}}, o, 8'h00});
        p = (d * $signed({40'h0, g})) >>> 22;
        if (f == 2'h1) return x;
        if (p > 64'sh7fffffff) return 32'h7fffffff;
        if (p < -64'sh80000000) return 32'h80000000;
        return p[31:0];
    endfunction
    // 64 back to back samples: the first 63 after the write must vanish
    task automatic smp(input icfs_sample_t x, input icfs_sample_t e);
        int n0;
        n0 = nout;
        @(negedge clk);
        filt_valid = 1'b1;
        filt_data = x;
        repeat (64) @(negedge clk);
        filt_valid = 1'b0;
        for (int i = 0; i < 6 && out_valid !== 1'b1; i++) @(negedge clk);
        chk("out_valid", out_valid, 1);
        chk("out_data", out_data, e);
        @(negedge clk);
        chk("out_count", nout - n0, 1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        filt_valid = 1'b0;
        filt_data = 32'h00000000;
        filter_path_select = 2'h2;
        cal_ofs_load = 1'b0;
        cal_gain_load = 1'b0;
        cal_ofs_value = 24'h000000;
        cal_gain_value = 24'h000000;
        do_reset();
        for (int a = 0; a < 9; a++) rdchk(8'(a + 2), rst_tab[a]);
        rdchk(8'h0b, 8'h00);
        chk("levels", {input_select, amp_chopping_enable, amp_gain_select, highpass_corner},
            {3'h0, 1'b1, 3'h0, 16'h0332});
        $display("test reset values done");
        for (int m = 0; m < 5; m++) begin
            icfs_host_model_inst.wr(8'h02, {1'b1, 3'(m), m[0], 3'(m + 2)});
            chk("cfg", {input_select, amp_chopping_enable, amp_gain_select},
                {3'(m), m[0], 3'(m + 2)});
            rdchk(8'h02, {1'b0, 3'(m), m[0], 3'(m + 2)});
        end
        icfs_host_model_inst.wr(8'h03, 8'ha5);
        icfs_host_model_inst.wr(8'h04, 8'h5a);
        icfs_host_model_inst.wr(8'h0c, 8'hff);
        chk("hpf", highpass_corner, 16'h5aa5);
        $display("test config done");
        for (int k = 0; k < 7; k++) begin
            filter_path_select = t_flt[k];
            wr24(8'h05, t_ofs[k]);
            wr24(8'h08, t_gain[k]);
            smp(t_in[k], ref_out(t_ofs[k], t_gain[k], t_flt[k], t_in[k]));
        end
        $display("test correction done");
        @(negedge clk);
        cal_ofs_load = 1'b1;
        cal_ofs_value = 24'h654321;
        cal_gain_load = 1'b1;
        cal_gain_value = 24'h3fffff;
        @(negedge clk);
        cal_ofs_load = 1'b0;
        cal_gain_load = 1'b0;
        rdchk(8'h05, 8'h21);
        rdchk(8'h07, 8'h65);
        rdchk(8'h0a, 8'h3f);
        $display("test calibration load done");
        do_reset();
        rdchk(8'h05, 8'h00);
        rdchk(8'h0a, 8'h40);
        $display("test second reset done");
        results();
    end
endmodule
bind icfs_top icfs_checker icfs_checker_inst (.*);
`default_nettype wire
